// ===== rtl/tpf_pkg.sv
/*
 Constants, register map and types of the track test fixture.
 Assumes a 10 MHz hclk and an AHB-Lite master with word transfers.
*/
package tpf_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_HDR_TIME = 8'h04;
  localparam logic [7:0] ADDR_TRK_ERR = 8'h08;
  localparam logic [7:0] ADDR_CH_ERR = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h14;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h18;
  localparam logic [7:0] ADDR_BURSTS = 8'h1C;
  // Control register layout and reset value
  localparam int CTRL_W = 3;
  localparam int CTRL_MOMENT = 0;
  localparam int CTRL_LEGACY = 1;
  localparam int CTRL_RUN = 2;
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h4;
  // Interrupt bit positions
  localparam int IRQ_W = 4;
  localparam int IRQ_TRK = 0;
  localparam int IRQ_CH = 1;
  localparam int IRQ_FRAME = 2;
  localparam int IRQ_BURST = 3;
  // Widths and counts
  localparam int N_TRK = 8;
  localparam int N_REC = 18;
  localparam int N_CH = 16;
  localparam int PRBS_W = 15;
  localparam logic [PRBS_W-1:0] PRBS_SEED = 15'h7FFF;
  localparam int TAP_A = 14;
  localparam int TAP_B = 13;
  localparam logic [3:0] LOCK_BITS = 4'hF;
  localparam logic [8:0] BURST_LAST = 9'h1FF;
  // Clock rates: the PLL step is a fraction of hclk
  localparam int CLK_HZ = 10_000_000;
  localparam logic [15:0] PLL_DEN = 16'h7D00;
  localparam logic [15:0] PLL_NUM_NATIVE = 16'h2370;
  localparam logic [1:0] TRK_DIV_LAST = 2'h3;
  // Frame layout in track bits
  localparam logic [14:0] FRAME_LAST_NATIVE = 15'h5897;
  localparam logic [14:0] FRAME_LAST_LEGACY = 15'h57E3;
  localparam logic [14:0] HDR_LAST = 15'h003F;
  localparam logic [31:0] HDR_SYNC = 32'hFFFF_FFFF;
  // Frame generator phase
  typedef enum logic [1:0] {PH_IDLE, PH_HEADER, PH_DATA} tpf_phase_t;
endpackage : tpf_pkg

// ===== rtl/tpf_top.sv
/*
 Track test fixture: frame generator, recovered track and channel
 checkers, error indicators and AHB-Lite register slave.
 Assumes one hclk domain; all card and panel inputs are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module tpf_top
  import tpf_pkg::*;
#(
  parameter logic [15:0] PLL_NUM_LEGACY = 16'h2328
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  input wire logic [N_TRK-1:0] src_sel_in,
  input wire logic [N_TRK-1:0] pattern_in,
  input wire logic led_reset_in,
  input wire logic rec_strobe_in,
  input wire logic [N_REC-1:0] rec_track_in,
  input wire logic ch_strobe_in,
  input wire logic ch_burst_in,
  input wire logic [N_CH-1:0] ch_data_in,
  output logic [N_TRK-1:0] track_data_out,
  output logic track_strobe_out,
  output logic frame_sync_out,
  output logic pll_legacy_out,
  output logic [2*N_REC-1:0] def_in_out,
  output logic [N_REC-1:0] trk_err_led,
  output logic [N_CH-1:0] ch_err_led
);

  ////////////////////////////////////////////////////////////////////
  // Input synchronisers
  localparam int SW = 2 * N_TRK + 4 + N_REC + N_CH;
  logic [SW-1:0] pin_raw;
  logic [SW-1:0] s1_reg;
  logic [SW-1:0] s2_reg;
  logic [SW-1:0] s3_reg;
  logic [SW-1:0] stab_reg;
  logic [SW-1:0] agree;

  assign pin_raw = {src_sel_in, pattern_in, led_reset_in, rec_strobe_in,
                    ch_strobe_in, ch_burst_in, rec_track_in, ch_data_in};
  assign agree = ~(s2_reg ^ s3_reg);

  // Three stages; a bit changes once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      stab_reg <= '0;
    end else begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      stab_reg <= (agree & s3_reg) | (~agree & stab_reg);
    end
  end

  logic [N_TRK-1:0] src_sel;
  logic [N_TRK-1:0] pattern;
  logic led_clr;
  logic rec_stb;
  logic ch_stb;
  logic ch_burst;
  logic [N_REC-1:0] rec_data;
  logic [N_CH-1:0] ch_data;
  assign {src_sel, pattern, led_clr, rec_stb, ch_stb, ch_burst,
          rec_data, ch_data} = stab_reg;

  ////////////////////////////////////////////////////////////////////
  // Register state
  logic [CTRL_W-1:0] ctrl_reg;
  logic [31:0] hdr_time_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_en_reg;
  logic [15:0] bursts_reg;
  logic moment;
  logic legacy;
  logic run;
  assign moment = ctrl_reg[CTRL_MOMENT];
  assign legacy = ctrl_reg[CTRL_LEGACY];
  assign run = ctrl_reg[CTRL_RUN];

  ////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states
  logic dp_wr_reg;
  logic [7:0] dp_addr_reg;
  logic ap_take;
  logic [31:0] rd_mux;
  logic wr_ctrl;
  logic wr_time;
  logic wr_en;
  logic wr_clr;
  assign ap_take = hsel && hready && htrans[1];
  assign wr_ctrl = dp_wr_reg && (dp_addr_reg == ADDR_CTRL);
  assign wr_time = dp_wr_reg && (dp_addr_reg == ADDR_HDR_TIME);
  assign wr_en = dp_wr_reg && (dp_addr_reg == ADDR_IRQ_EN);
  assign wr_clr = dp_wr_reg && (dp_addr_reg == ADDR_IRQ_CLR);

  // Read decode; unmapped and write-only offsets read zero
  always_comb begin
    rd_mux = '0;
    unique case (haddr[7:0])
      ADDR_CTRL: rd_mux[CTRL_W-1:0] = ctrl_reg;
      ADDR_HDR_TIME: rd_mux = hdr_time_reg;
      ADDR_TRK_ERR: rd_mux[N_REC-1:0] = trk_err_led;
      ADDR_CH_ERR: rd_mux[N_CH-1:0] = ch_err_led;
      ADDR_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat_reg;
      ADDR_IRQ_EN: rd_mux[IRQ_W-1:0] = irq_en_reg;
      ADDR_BURSTS: rd_mux[15:0] = bursts_reg;
      default: rd_mux = '0;
    endcase
  end

  // Address phase capture and read data for the following data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_reg <= 1'b0;
      dp_addr_reg <= '0;
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      dp_wr_reg <= ap_take && hwrite;
      if (ap_take) begin
        dp_addr_reg <= haddr[7:0];
        if (!hwrite) begin
          hrdata <= rd_mux;
        end
      end
    end
  end

  // Configuration: defaults at reset, changed only by a bus write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= CTRL_RST;
      irq_en_reg <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= hwdata[CTRL_W-1:0];
      end
      if (wr_en) begin
        irq_en_reg <= hwdata[IRQ_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // PLL step and track clock divider
  logic [15:0] acc_reg;
  logic [15:0] pll_num;
  logic [16:0] acc_sum;
  logic osc_tick;
  logic [1:0] div_reg;
  logic trk_tick;
  assign pll_num = legacy ? PLL_NUM_LEGACY : PLL_NUM_NATIVE;
  assign acc_sum = {1'b0, acc_reg} + {1'b0, pll_num};
  assign osc_tick = acc_sum >= {1'b0, PLL_DEN};
  assign trk_tick = osc_tick && (div_reg == TRK_DIV_LAST);

  // Fractional accumulator locked to hclk, then divide by four
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_reg <= '0;
      div_reg <= '0;
      pll_legacy_out <= 1'b0;
    end else begin
      pll_legacy_out <= legacy;
      if (osc_tick) begin
        acc_reg <= 16'(acc_sum - {1'b0, PLL_DEN});
        div_reg <= div_reg + 2'h1;
      end else begin
        acc_reg <= acc_sum[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Frame generator
  tpf_phase_t phase_reg;
  logic [14:0] bit_reg;
  logic [14:0] frame_last;
  logic [63:0] hdr_sh_reg;
  logic [PRBS_W-1:0] gen_reg;
  logic [2:0] pat_idx_reg;
  logic frame_end;
  logic frame_evt;
  assign frame_last = legacy ? FRAME_LAST_LEGACY : FRAME_LAST_NATIVE;
  assign frame_end = trk_tick && (bit_reg == frame_last);
  assign frame_evt = frame_end && (phase_reg == PH_DATA);

  // Phase sequence: header bits then data bits, per frame
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_reg <= PH_IDLE;
      bit_reg <= '0;
    end else if (!run) begin
      phase_reg <= PH_IDLE;
      bit_reg <= '0;
    end else if (trk_tick) begin
      unique case (phase_reg)
        PH_IDLE: begin
          phase_reg <= PH_HEADER;
          bit_reg <= '0;
        end
        PH_HEADER: begin
          bit_reg <= bit_reg + 15'h0001;
          if (bit_reg == HDR_LAST) begin
            phase_reg <= PH_DATA;
          end
        end
        PH_DATA: begin
          if (frame_end) begin
            phase_reg <= PH_HEADER;
            bit_reg <= '0;
          end else begin
            bit_reg <= bit_reg + 15'h0001;
          end
        end
      endcase
    end
  end

  // Header time runs: advanced each frame, bus write wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hdr_time_reg <= '0;
    end else if (wr_time) begin
      hdr_time_reg <= hwdata;
    end else if (frame_evt) begin
      hdr_time_reg <= hdr_time_reg + 32'h0000_0001;
    end
  end

  // Header shifter loaded as a frame starts, sync then time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hdr_sh_reg <= '0;
    end else if (trk_tick && run) begin
      if (phase_reg != PH_HEADER) begin
        hdr_sh_reg <= {HDR_SYNC, hdr_time_reg};
      end else begin
        hdr_sh_reg <= {hdr_sh_reg[62:0], 1'b0};
      end
    end
  end

  // Generator and pattern index step only on data bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gen_reg <= PRBS_SEED;
      pat_idx_reg <= '0;
    end else if (trk_tick && (phase_reg == PH_DATA)) begin
      gen_reg <= {gen_reg[PRBS_W-2:0], gen_reg[TAP_A] ^ gen_reg[TAP_B]};
      pat_idx_reg <= frame_end ? 3'h0 : pat_idx_reg + 3'h1;
    end
  end

  // Track outputs: header bits, or per-track data source
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      track_data_out <= '0;
      track_strobe_out <= 1'b0;
      frame_sync_out <= 1'b0;
    end else begin
      track_strobe_out <= trk_tick && (phase_reg != PH_IDLE);
      if (trk_tick) begin
        frame_sync_out <= (phase_reg == PH_HEADER);
        for (int i = 0; i < N_TRK; i++) begin
          if (phase_reg == PH_HEADER) begin
            track_data_out[i] <= hdr_sh_reg[63];
          end else if (phase_reg == PH_DATA) begin
            track_data_out[i] <= src_sel[i] ? pattern[pat_idx_reg]
                                            : gen_reg[TAP_A];
          end else begin
            track_data_out[i] <= 1'b0;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Recovered track fan-out and strobe edges
  logic rec_stb_q_reg;
  logic ch_stb_q_reg;
  logic rec_samp;
  logic ch_samp;
  assign rec_samp = rec_stb && !rec_stb_q_reg;
  assign ch_samp = ch_stb && !ch_stb_q_reg && ch_burst;

  // Each recovered track is driven to two deformatter pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rec_stb_q_reg <= 1'b0;
      ch_stb_q_reg <= 1'b0;
      def_in_out <= '0;
    end else begin
      rec_stb_q_reg <= rec_stb;
      ch_stb_q_reg <= ch_stb;
      for (int i = 0; i < N_REC; i++) begin
        def_in_out[2*i] <= rec_data[i];
        def_in_out[2*i+1] <= rec_data[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Track checkers: self-aligning predict per track
  logic [N_REC-1:0] trk_mis;
  logic [N_CH-1:0] ch_mis;

  for (genvar g = 0; g < N_REC; g++) begin : g_trk
    logic [PRBS_W-1:0] sh_reg;
    logic [3:0] lock_reg;
    logic led_reg;
    assign trk_mis[g] = rec_samp && (lock_reg == LOCK_BITS)
                        && (rec_data[g] != (sh_reg[TAP_A] ^ sh_reg[TAP_B]));
    assign trk_err_led[g] = led_reg;
    // Predict always loads from the stream; checks start once fifteen bits are in
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        sh_reg <= '0;
        lock_reg <= '0;
      end else if (rec_samp) begin
        sh_reg <= {sh_reg[PRBS_W-2:0], rec_data[g]};
        if (lock_reg != LOCK_BITS) begin
          lock_reg <= lock_reg + 4'h1;
        end
      end
    end
    // Latched or momentary indicator, a mismatch beats the clear
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        led_reg <= 1'b0;
      end else if (trk_mis[g]) begin
        led_reg <= 1'b1;
      end else if (led_clr) begin
        led_reg <= 1'b0;
      end else if (rec_samp && moment) begin
        led_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Channel checkers: independent predict per output channel
  for (genvar g = 0; g < N_CH; g++) begin : g_ch
    logic [PRBS_W-1:0] sh_reg;
    logic [3:0] lock_reg;
    logic led_reg;
    assign ch_mis[g] = ch_samp && (lock_reg == LOCK_BITS)
                       && (ch_data[g] != (sh_reg[TAP_A] ^ sh_reg[TAP_B]));
    assign ch_err_led[g] = led_reg;
    // Alignment runs on burst bits only
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        sh_reg <= '0;
        lock_reg <= '0;
      end else if (ch_samp) begin
        sh_reg <= {sh_reg[PRBS_W-2:0], ch_data[g]};
        if (lock_reg != LOCK_BITS) begin
          lock_reg <= lock_reg + 4'h1;
        end
      end
    end
    // Same indicator policy as the tracks
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        led_reg <= 1'b0;
      end else if (ch_mis[g]) begin
        led_reg <= 1'b1;
      end else if (led_clr) begin
        led_reg <= 1'b0;
      end else if (ch_samp && moment) begin
        led_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Burst bit counter and completed burst count
  logic [8:0] burst_bit_reg;
  logic burst_evt;
  assign burst_evt = ch_samp && (burst_bit_reg == BURST_LAST);

  // Counts 512 bits per burst; restarts when the burst line drops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      burst_bit_reg <= '0;
      bursts_reg <= '0;
    end else begin
      if (!ch_burst) begin
        burst_bit_reg <= '0;
      end else if (ch_samp) begin
        burst_bit_reg <= burst_bit_reg + 9'h001;
      end
      if (burst_evt) begin
        bursts_reg <= bursts_reg + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Interrupt status, set wins over clear
  logic [IRQ_W-1:0] irq_set;
  assign irq_set = {burst_evt, frame_evt, |ch_mis, |trk_mis};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_reg <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat_reg <= irq_set | (irq_stat_reg & ~(wr_clr ? hwdata[IRQ_W-1:0] : 4'h0));
      irq <= |(irq_stat_reg & irq_en_reg);
    end
  end

endmodule : tpf_top
`default_nettype wire

// ===== tb/tb_top.sv
/*
 Self-checking bench of the track test fixture.
 Assumes tpf_top, the card model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_top;
  import tpf_pkg::*;
  typedef struct {string nm; logic [31:0] v;} tpf_note_t;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, led_reset_in = 0, dph_rd = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, htime = '0;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, irq, rec_strobe_in, ch_strobe_in, ch_burst_in;
  logic track_strobe_out, frame_sync_out, pll_legacy_out, chk_data = 1;
  logic [N_TRK-1:0] src_sel_in = '0, pattern_in = '0, track_data_out, ex;
  logic [N_REC-1:0] rec_track_in, trk_err_led, rec_flip = '0;
  logic [N_CH-1:0] ch_data_in, ch_err_led, ch_flip = '0;
  logic [2*N_REC-1:0] def_in_out;
  logic [PRBS_W-1:0] pr = PRBS_SEED;
  int n_errors = 0, n_tests = 0, hb = 0, idx = 0;
  tpf_note_t q[$];
  tpf_note_t nt;
  always #50 hclk = ~hclk;
  tpf_top tpf_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
    .src_sel_in(src_sel_in), .pattern_in(pattern_in), .led_reset_in(led_reset_in),
    .rec_strobe_in(rec_strobe_in), .rec_track_in(rec_track_in), .ch_strobe_in(ch_strobe_in),
    .ch_burst_in(ch_burst_in), .ch_data_in(ch_data_in), .track_data_out(track_data_out),
    .track_strobe_out(track_strobe_out), .frame_sync_out(frame_sync_out),
    .pll_legacy_out(pll_legacy_out), .def_in_out(def_in_out), .trk_err_led(trk_err_led),
    .ch_err_led(ch_err_led));
  tpf_card_model tpf_card_model_inst (.hclk(hclk), .hresetn(hresetn), .rec_flip(rec_flip),
    .ch_flip(ch_flip), .rec_strobe(rec_strobe_in), .rec_data(rec_track_in),
    .ch_strobe(ch_strobe_in), .ch_burst(ch_burst_in), .ch_data(ch_data_in));
  //////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("counts: %0d checks, %0d mismatches", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc
  // Bounded wait for hready at a rising edge
  task automatic wait_rdy;
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (hreadyout !== 1'b1) begin
      n_errors++;
      end_of_test();
    end
  endtask : wait_rdy
  // One word transfer; a read notes its expected value
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input string nm);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    if (!w) begin
      q.push_back('{nm, d});
      dph_rd <= 1'b1;
    end
    wait_rdy();
    dph_rd <= 1'b0;
  endtask : bus
  // One bad bit on the chosen lanes: the mask spans one strobe period
  task automatic flip(input logic [N_REC-1:0] r, input logic [N_CH-1:0] c);
    @(posedge hclk);
    rec_flip <= r;
    ch_flip <= c;
    cyc(12);
    rec_flip <= '0;
    ch_flip <= '0;
  endtask : flip
  //////////////////////////////////////////////////////////////
  // Read data compared with the oldest note
  always @(posedge hclk) begin
    if (dph_rd === 1'b1 && hreadyout === 1'b1) begin
      nt = q.pop_front();
      `CHK(nt.nm, nt.v, hrdata)
    end
  end
  // Generated track bits against the bench's own sequence
  always @(posedge hclk) begin
    if (track_strobe_out === 1'b1) begin
      if (frame_sync_out) begin
        if (hb < 32) `CHK("hdr sync", 8'hFF, track_data_out)
        else `CHK("hdr time", {8{htime[63-hb]}}, track_data_out)
        hb++;
      end else begin
        hb = 0;
        if (chk_data) begin
          for (int i = 0; i < N_TRK; i++) ex[i] = src_sel_in[i] ? pattern_in[idx] : pr[14];
          `CHK("track data", ex, track_data_out)
          pr = {pr[13:0], pr[TAP_A] ^ pr[TAP_B]};
          idx = (idx + 1) % 8;
        end
      end
    end
  end
  // Main sequence
  initial begin
    void'($urandom(99));
    src_sel_in <= 8'($urandom);
    pattern_in <= 8'($urandom);
    cyc(20);
    hresetn <= 1'b1;
    bus(0, ADDR_CTRL, 32'h4, "ctrl reset");
    bus(0, 8'h40, 32'h0, "unmapped");
    cyc(300);
    bus(0, ADDR_TRK_ERR, 32'h0, "trk lock");
    bus(0, ADDR_CH_ERR, 32'h0, "ch lock");
    $display("test reset done");
    bus(1, ADDR_IRQ_EN, 32'h0, "");
    flip(18'h20, 16'h0);
    cyc(480);
    `CHK("trk led", 18'h20, trk_err_led)
    `CHK("irq masked", 1'b0, irq)
    bus(0, ADDR_TRK_ERR, 32'h20, "trk err");
    flip(18'h0, 16'h200);
    cyc(480);
    `CHK("ch led", 16'h200, ch_err_led)
    bus(0, ADDR_CH_ERR, 32'h200, "ch err");
    bus(1, ADDR_IRQ_EN, 32'h3, "");
    cyc(3);
    `CHK("irq on", 1'b1, irq)
    bus(1, ADDR_IRQ_CLR, 32'hF, "");
    cyc(3);
    `CHK("irq clr", 1'b0, irq)
    $display("test errors done");
    led_reset_in <= 1'b1;
    cyc(10);
    led_reset_in <= 1'b0;
    cyc(6);
    `CHK("trk led clr", 18'h0, trk_err_led)
    `CHK("ch led clr", 16'h0, ch_err_led)
    bus(1, ADDR_CTRL, 32'h5, "");
    flip(18'h4, 16'h0);
    cyc(480);
    `CHK("moment led", 18'h0, trk_err_led)
    `CHK("moment irq", 1'b1, irq)
    bus(0, ADDR_IRQ_STAT, 32'h1, "irq stat");
    bus(0, ADDR_BURSTS, 32'h0, "bursts none");
    bus(1, ADDR_IRQ_CLR, 32'hF, "");
    $display("test indicators done");
    bus(1, ADDR_CTRL, 32'h6, "");
    cyc(3);
    `CHK("pll legacy", 1'b1, pll_legacy_out)
    bus(0, ADDR_CTRL, 32'h6, "ctrl rw");
    bus(1, ADDR_CTRL, 32'h4, "");
    cyc(3);
    `CHK("pll native", 1'b0, pll_legacy_out)
    $display("test pll done");
    chk_data = 1'b0;
    bus(1, ADDR_CTRL, 32'h0, "");
    cyc(40);
    htime = $urandom;
    bus(1, ADDR_HDR_TIME, htime, "");
    bus(0, ADDR_HDR_TIME, htime, "hdr time rw");
    bus(1, ADDR_CTRL, 32'h4, "");
    cyc(1100);
    $display("test header done");
    end_of_test();
  end
endmodule : tb_top
`undef CHK
`default_nettype wire

// ===== tb/tpf_asserts.sv
/*
 Checker of the track test fixture, watching the top module ports.
 Assumes a single hclk domain and the bind statement at the foot.
*/
`timescale 1ns/1ps
`default_nettype none
module tpf_asserts
  import tpf_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic irq,
  input wire logic led_reset_in,
  input wire logic rec_strobe_in,
  input wire logic [N_REC-1:0] rec_track_in,
  input wire logic ch_strobe_in,
  input wire logic [N_TRK-1:0] track_data_out,
  input wire logic track_strobe_out,
  input wire logic frame_sync_out,
  input wire logic [2*N_REC-1:0] def_in_out,
  input wire logic [N_REC-1:0] trk_err_led,
  input wire logic [N_CH-1:0] ch_err_led
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rs_q, cs_q;
  logic [2:0] rc, cc;
  logic [5:0] gap;
  logic [6:0] hc;
  logic [2*N_REC-1:0] dup;
  //////////////////////////////////////////////////////////////
  // Cycles since each card strobe rose, saturating at seven
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rs_q <= 1'b0;
      cs_q <= 1'b0;
      rc <= 3'h7;
      cc <= 3'h7;
    end else begin
      rs_q <= rec_strobe_in;
      cs_q <= ch_strobe_in;
      rc <= (rec_strobe_in && !rs_q) ? 3'h0 : (rc == 3'h7 ? rc : rc + 3'h1);
      cc <= (ch_strobe_in && !cs_q) ? 3'h0 : (cc == 3'h7 ? cc : cc + 3'h1);
    end
  end
  // Track bit spacing and header bit count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap <= 6'h3F;
      hc <= 7'h00;
    end else begin
      gap <= track_strobe_out ? 6'h01 : (gap == 6'h3F ? gap : gap + 6'h01);
      hc <= !frame_sync_out ? 7'h00 : (track_strobe_out ? hc + 7'h01 : hc);
    end
  end
  // Each recovered lane doubled onto two deformatter pins
  always_comb begin
    for (int i = 0; i < N_REC; i++) begin
      dup[2*i] = rec_track_in[i];
      dup[2*i+1] = rec_track_in[i];
    end
  end
  //////////////////////////////////////////////////////////////
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
  a_def_dup: assert property ($stable(rec_track_in)[*8] |-> def_in_out == dup)
    else $error("deformatter pins do not follow recovered lanes");
  a_trk_led_time: assert property ((trk_err_led & ~$past(trk_err_led)) != '0 |-> rc inside {[3:6]})
    else $error("track error set away from a sample");
  a_ch_led_time: assert property ((ch_err_led & ~$past(ch_err_led)) != '0 |-> cc inside {[3:6]})
    else $error("channel error set away from a sample");
  a_led_clear: assert property (led_reset_in[*8] |-> trk_err_led == '0 && ch_err_led == '0)
    else $error("indicator reset did not clear");
  a_trk_gap: assert property (track_strobe_out && gap < 6'd30 |-> gap inside {[14:15]})
    else $error("track bit spacing wrong");
  a_hdr_ones: assert property (frame_sync_out && track_strobe_out && hc < 7'd32 |-> track_data_out == 8'hFF)
    else $error("header sync bit not one");
  a_hdr_len: assert property ($fell(frame_sync_out) |-> hc == 7'd64)
    else $error("header length wrong");
  c_trk_err: cover property ($rose(trk_err_led[5]));
  c_ch_err: cover property ($rose(ch_err_led[9]));
  c_hdr_end: cover property ($fell(frame_sync_out));
  c_irq: cover property ($rose(irq));
endmodule : tpf_asserts
bind tpf_top tpf_asserts tpf_asserts_inst (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
  .led_reset_in(led_reset_in), .rec_strobe_in(rec_strobe_in), .rec_track_in(rec_track_in),
  .ch_strobe_in(ch_strobe_in), .track_data_out(track_data_out),
  .track_strobe_out(track_strobe_out), .frame_sync_out(frame_sync_out),
  .def_in_out(def_in_out), .trk_err_led(trk_err_led), .ch_err_led(ch_err_led)
);
`default_nettype wire

// ===== tb/tpf_card_model.sv
/*
 Model of the recovery and deformatter cards under test.
 Assumes hclk; sends one PRBS bit per strobe period of 2*HALF cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module tpf_card_model
  import tpf_pkg::*;
#(
  parameter int HALF = 6
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [N_REC-1:0] rec_flip,
  input wire logic [N_CH-1:0] ch_flip,
  output logic rec_strobe,
  output logic [N_REC-1:0] rec_data,
  output logic ch_strobe,
  output logic ch_burst,
  output logic [N_CH-1:0] ch_data
);
  logic [PRBS_W-1:0] rp, cp;
  int ph, bc;
  //////////////////////////////////////////////////////////////
  // Data changes as the strobe falls, flipped lanes give one bad bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph <= 0;
      bc <= 0;
      rp <= 15'h1234;
      cp <= 15'h0ABC;
      rec_strobe <= 1'b0;
      ch_strobe <= 1'b0;
      ch_burst <= 1'b0;
      rec_data <= '0;
      ch_data <= '0;
    end else begin
      ph <= (ph == 2*HALF-1) ? 0 : ph + 1;
      rec_strobe <= ph >= HALF;
      ch_strobe <= ph >= HALF;
      if (ph == 0) begin
        rp <= {rp[13:0], rp[14] ^ rp[13]};
        rec_data <= {N_REC{rp[14]}} ^ rec_flip;
        bc <= (bc == 513) ? 0 : bc + 1;
        ch_burst <= bc < 512;
        if (bc < 512) begin
          cp <= {cp[13:0], cp[14] ^ cp[13]};
          ch_data <= {N_CH{cp[14]}} ^ ch_flip;
        end
      end
    end
  end
endmodule : tpf_card_model
`default_nettype wire
